// File: core/dcso_core.sv
// serial register front end and output state control of the converter
// assumes host clock idles low, host drives sdin for the falling edge
// and samples sdo on the falling edge; frame_n low frames a transfer
`timescale 1ns/1ps
`default_nettype none
module dcso_core (
  // system clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  // serial link
  input wire logic link_sclk,
  input wire logic link_frame_n,
  input wire logic link_sdin,
  output logic link_sdo,
  output logic link_sdo_oe_n,
  // control pins, active low, asynchronous
  input wire logic load_dac_strobe_n,
  input wire logic clear_to_code_n,
  input wire logic device_reset_n,
  // converter side
  output logic [15:0] dac_code,
  output logic coding_select,
  output logic bias_comp_select,
  output logic amp_power_en,
  output dcso_pkg::dcso_out_state_t out_state
);

  // link domain state
  logic [4:0] bit_cnt_reg;
  logic [22:0] shift_in_reg;
  dcso_pkg::dcso_frame_t frame_hold_reg;
  logic frame_tgl_reg;
  logic [23:0] rd_shift_reg;

  // system domain state
  dcso_pkg::dcso_exec_t exec_st_reg;
  dcso_pkg::dcso_exec_t exec_st_next;
  logic tgl_seen_reg;
  logic [2:0] pin_prev_reg;
  logic [15:0] input_reg;
  logic [15:0] input_next;
  logic [15:0] active_reg;
  logic [15:0] active_next;
  logic [15:0] clear_reg;
  logic [15:0] clear_next;
  dcso_pkg::dcso_ctrl_t ctrl_reg;
  dcso_pkg::dcso_ctrl_t ctrl_next;
  dcso_pkg::dcso_ctrl_t ctrl_default;
  logic [23:0] rb_word_reg;
  logic [23:0] rb_word_next;
  dcso_pkg::dcso_out_state_t out_state_reg;
  dcso_pkg::dcso_out_state_t out_state_next;

  // synchronised levels
  logic [4:0] sync_in;
  logic [4:0] sync_out;
  logic tgl_s;
  logic frame_n_s;
  logic load_dac_strobe_s;
  logic clr_s;
  logic rst_pin_s;

  // bits shifted in on falling edges; counter cleared whenever the
  // frame is closed, since the host clock stops outside frames
  always_ff @(negedge link_sclk or posedge link_frame_n) begin
    if (link_frame_n) begin
      bit_cnt_reg <= 5'h00;
    end else if (bit_cnt_reg != dcso_pkg::FRAME_FULL) begin
      bit_cnt_reg <= bit_cnt_reg + 5'h01;
    end
  end

  // shift register; bits after the 24th are dropped
  always_ff @(negedge link_sclk) begin
    shift_in_reg <= {shift_in_reg[21:0], link_sdin};
  end

  // the 24th bit completes a frame: hold it and toggle the event
  always_ff @(negedge link_sclk or posedge srst) begin
    if (srst) begin
      frame_hold_reg <= '0;
      frame_tgl_reg <= 1'b0;
    end else if (bit_cnt_reg == dcso_pkg::FRAME_LAST) begin
      frame_hold_reg <= {shift_in_reg, link_sdin};
      frame_tgl_reg <= ~frame_tgl_reg;
    end
  end

  // readback word loaded on the first rising edge of a frame; the
  // word is only changed between frames, so it is quiet when sampled
  always_ff @(posedge link_sclk or posedge srst) begin
    if (srst) begin
      rd_shift_reg <= '0;
    end else if (bit_cnt_reg == 5'h00) begin
      rd_shift_reg <= rb_word_reg;
    end else begin
      rd_shift_reg <= {rd_shift_reg[22:0], 1'b0};
    end
  end

  // sdo only driven inside a frame and when not disabled
  assign link_sdo = rd_shift_reg[23];
  assign link_sdo_oe_n = link_frame_n | ctrl_reg.sdo_disable;

  // all asynchronous inputs pass two flip-flops
  assign sync_in = {frame_tgl_reg, link_frame_n, load_dac_strobe_n,
                    clear_to_code_n, device_reset_n};

  dcso_sync #(
    .WIDTH(5),
    .INIT(5'h0F)
  ) u_sync (
    .clk(sys_clk),
    .rst(srst),
    .d(sync_in),
    .q(sync_out)
  );

  assign tgl_s = sync_out[4];
  assign frame_n_s = sync_out[3];
  assign load_dac_strobe_s = sync_out[2];
  assign clr_s = sync_out[1];
  assign rst_pin_s = sync_out[0];

  // frame events and pin edges, seen on the system clock
  wire tgl_edge = tgl_s ^ tgl_seen_reg;
  wire load_dac_strobe_fall = pin_prev_reg[2] & ~load_dac_strobe_s;
  wire clr_fall = pin_prev_reg[1] & ~clr_s;
  wire rst_pin_low = ~rst_pin_s;

  // a completed frame waits for the frame to close before acting
  always_comb begin
    exec_st_next = exec_st_reg;
    case (exec_st_reg)
      dcso_pkg::ST_IDLE: begin
        if (tgl_edge) begin
          exec_st_next = dcso_pkg::ST_HELD;
        end
      end
      dcso_pkg::ST_HELD: begin
        if (frame_n_s && !tgl_edge) begin
          exec_st_next = dcso_pkg::ST_IDLE;
        end
      end
      default: begin
        exec_st_next = dcso_pkg::ST_IDLE;
      end
    endcase
  end

  // frame decode
  wire exec = (exec_st_reg == dcso_pkg::ST_HELD) && frame_n_s;
  wire is_wr = exec && (frame_hold_reg.rw == dcso_pkg::RW_WRITE);
  wire is_rd = exec && (frame_hold_reg.rw == dcso_pkg::RW_READ);
  wire [19:0] fdata = frame_hold_reg.data;
  wire [15:0] fcode = fdata[dcso_pkg::CODE_LSB +: 16];
  wire wr_dac = is_wr && (frame_hold_reg.addr == dcso_pkg::ADDR_DAC);
  wire wr_ctrl = is_wr && (frame_hold_reg.addr == dcso_pkg::ADDR_CTRL);
  wire wr_clear = is_wr && (frame_hold_reg.addr == dcso_pkg::ADDR_CLEAR);
  // strobe register is write only: a read of it returns no data bits
  wire wr_soft = is_wr
                 && (frame_hold_reg.addr == dcso_pkg::ADDR_SOFT);

  // software strobes; load and clear gated by the opposite pin level, reset ungated
  wire sw_load = wr_soft && fdata[dcso_pkg::SOFT_LOAD_POS]
                 && clr_s;
  wire sw_clear = wr_soft && fdata[dcso_pkg::SOFT_CLEAR_POS]
                  && load_dac_strobe_s;
  wire sw_reset = wr_soft && fdata[dcso_pkg::SOFT_RESET_POS];

  // a strobe bit and a pin pulse land on the same event
  wire load_evt = sw_load || load_dac_strobe_fall;
  wire clear_evt = sw_clear || clr_fall;

  // everything that returns the device to its power-on state
  wire dev_rst = srst || sw_reset || rst_pin_low;

  // power-on control: clamped, tristated, twos complement
  assign ctrl_default = '{
    sdo_disable: dcso_pkg::SDODIS_RESET,
    coding_select: dcso_pkg::CODING_RESET,
    ground_clamp_bit: dcso_pkg::CLAMP_RESET,
    dac_tristate_bit: dcso_pkg::TRI_RESET,
    bias_comp_select: dcso_pkg::BIAS_RESET
  };

  // control register write; state held until rewritten
  always_comb begin
    ctrl_next = ctrl_reg;
    if (wr_ctrl) begin
      ctrl_next.sdo_disable = fdata[dcso_pkg::CTRL_SDODIS_POS];
      ctrl_next.coding_select = fdata[dcso_pkg::CTRL_CODING_POS];
      ctrl_next.ground_clamp_bit = fdata[dcso_pkg::CTRL_CLAMP_POS];
      ctrl_next.dac_tristate_bit = fdata[dcso_pkg::CTRL_TRI_POS];
      ctrl_next.bias_comp_select = fdata[dcso_pkg::CTRL_BIAS_POS];
    end
  end

  // pending code and clear code; low four data bits are don't care
  assign input_next = wr_dac ? fcode : input_reg;
  assign clear_next = wr_clear ? fcode : clear_reg;

  // active register: clear wins over load when both arrive together;
  // the code is passed through untouched whatever the coding
  always_comb begin
    active_next = active_reg;
    if (clear_evt) begin
      active_next = clear_reg;
    end else if (load_evt) begin
      active_next = input_reg;
    end
  end

  // readback word; the strobe register reads as zero
  always_comb begin
    rb_word_next = rb_word_reg;
    if (is_rd) begin
      rb_word_next = {dcso_pkg::RW_READ, frame_hold_reg.addr, 20'h00000};
      if (frame_hold_reg.addr == dcso_pkg::ADDR_DAC) begin
        rb_word_next[dcso_pkg::CODE_LSB +: 16] = active_reg;
      end else if (frame_hold_reg.addr == dcso_pkg::ADDR_CTRL) begin
        rb_word_next[dcso_pkg::CTRL_SDODIS_POS] = ctrl_reg.sdo_disable;
        rb_word_next[dcso_pkg::CTRL_CODING_POS] = ctrl_reg.coding_select;
        rb_word_next[dcso_pkg::CTRL_CLAMP_POS] = ctrl_reg.ground_clamp_bit;
        rb_word_next[dcso_pkg::CTRL_TRI_POS] = ctrl_reg.dac_tristate_bit;
        rb_word_next[dcso_pkg::CTRL_BIAS_POS] = ctrl_reg.bias_comp_select;
      end else if (frame_hold_reg.addr == dcso_pkg::ADDR_CLEAR) begin
        rb_word_next[dcso_pkg::CODE_LSB +: 16] = clear_reg;
      end
    end
  end

  // output state decode from the next control value; clamp overrides
  always_comb begin
    out_state_next.clamp_engaged = ctrl_next.ground_clamp_bit;
    out_state_next.tristated = ctrl_next.dac_tristate_bit
                               && !ctrl_next.ground_clamp_bit;
    out_state_next.normal = !ctrl_next.dac_tristate_bit
                            && !ctrl_next.ground_clamp_bit;
  end

  // frame sequencing and pin history; only a hard reset clears these
  // so that a frame that commanded a reset is not replayed
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      exec_st_reg <= dcso_pkg::ST_IDLE;
      tgl_seen_reg <= 1'b0;
      pin_prev_reg <= 3'h7;
    end else begin
      exec_st_reg <= exec_st_next;
      tgl_seen_reg <= tgl_s;
      pin_prev_reg <= {load_dac_strobe_s, clr_s, rst_pin_s};
    end
  end

  // device registers; a reset strobe or pin acts like power-on
  always_ff @(posedge sys_clk) begin
    if (dev_rst) begin
      input_reg <= dcso_pkg::DAC_RESET;
      active_reg <= dcso_pkg::DAC_RESET;
      clear_reg <= dcso_pkg::CLEAR_RESET;
      ctrl_reg <= ctrl_default;
      rb_word_reg <= '0;
    end else begin
      input_reg <= input_next;
      active_reg <= active_next;
      clear_reg <= clear_next;
      ctrl_reg <= ctrl_next;
      rb_word_reg <= rb_word_next;
    end
  end

  // registered output state; reset enters clamped tristate
  always_ff @(posedge sys_clk) begin
    if (dev_rst) begin
      out_state_reg <= '{clamp_engaged: 1'b1, tristated: 1'b0,
                         normal: 1'b0};
    end else begin
      out_state_reg <= out_state_next;
    end
  end

  // converter outputs: code is shown only as the state permits, the
  // converter itself sees the raw code in the selected coding
  assign dac_code = active_reg;
  assign coding_select = ctrl_reg.coding_select;
  assign bias_comp_select = ctrl_reg.bias_comp_select;
  assign amp_power_en = ~ctrl_reg.bias_comp_select;
  assign out_state = out_state_reg;

endmodule // dcso_core
`default_nettype wire

// File: core/dcso_pkg.sv
// constants and carrier types for the converter control core
// assumes a host that sends 24-bit frames, msb first, on its own clock
// Summary of operation
// - address 011 holds clear code in DB19..DB4; DB3..DB0 ignored
// - address 100 write only; DB2 reset, DB1 clear, DB0 load strobe
// - a strobe bit written 1 acts like pulsing its pin low
// - software clear is ignored while the load pin is low
// - software load is ignored while the clear pin is low
// - load strobe moves the pending code into the active register
// - clear strobe loads the active register with the clear code
// - clear result follows current coding; stored code is never converted
// - reset strobe returns the whole device to its power-on state
// - power-on sets defaults, tristates converter, engages ground clamp
// - tristate and clamp stay until control register says otherwise
// - after release the output shows the active register value
// - both clear normal; tristate alone floats; clamp grounds always
// - frame bit DB23 zero writes, one reads the addressed register
// - coding select resets to zero, twos complement; one is offset binary
// - clamp bit overrides tristate bit; reset enters clamped tristate
package dcso_pkg;

  // frame layout
  localparam int FRAME_BITS = 24;
  localparam logic [4:0] FRAME_LAST = 5'h17;
  localparam logic [4:0] FRAME_FULL = 5'h18;
  localparam logic RW_WRITE = 1'b0;
  localparam logic RW_READ = 1'b1;
  localparam int CODE_LSB = 4;

  // register addresses
  localparam logic [2:0] ADDR_DAC = 3'h1;
  localparam logic [2:0] ADDR_CTRL = 3'h2;
  localparam logic [2:0] ADDR_CLEAR = 3'h3;
  localparam logic [2:0] ADDR_SOFT = 3'h4;

  // software strobe positions
  localparam int SOFT_LOAD_POS = 0;
  localparam int SOFT_CLEAR_POS = 1;
  localparam int SOFT_RESET_POS = 2;

  // control field positions
  localparam int CTRL_BIAS_POS = 1;
  localparam int CTRL_TRI_POS = 2;
  localparam int CTRL_CLAMP_POS = 3;
  localparam int CTRL_CODING_POS = 4;
  localparam int CTRL_SDODIS_POS = 5;

  // values after reset
  localparam logic [15:0] DAC_RESET = 16'h8000;
  localparam logic [15:0] CLEAR_RESET = 16'h0000;
  localparam logic BIAS_RESET = 1'b1;
  localparam logic TRI_RESET = 1'b1;
  localparam logic CLAMP_RESET = 1'b1;
  localparam logic CODING_RESET = 1'b0;
  localparam logic SDODIS_RESET = 1'b0;

  typedef struct packed {
    logic rw;
    logic [2:0] addr;
    logic [19:0] data;
  } dcso_frame_t;

  typedef struct packed {
    logic sdo_disable;
    logic coding_select;
    logic ground_clamp_bit;
    logic dac_tristate_bit;
    logic bias_comp_select;
  } dcso_ctrl_t;

  typedef struct packed {
    logic clamp_engaged;
    logic tristated;
    logic normal;
  } dcso_out_state_t;

  typedef enum logic {ST_IDLE, ST_HELD} dcso_exec_t;

endpackage

// File: core/dcso_sync.sv
// two-stage synchroniser for a group of single-bit levels
// assumes each bit is an independent level from another domain
`timescale 1ns/1ps
`default_nettype none
module dcso_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // levels
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] q_reg;

  // first stage feeds only the second
  always_ff @(posedge clk) begin
    if (rst) begin
      meta_reg <= INIT;
      q_reg <= INIT;
    end else begin
      meta_reg <= d;
      q_reg <= meta_reg;
    end
  end

  assign q = q_reg;

endmodule // dcso_sync
`default_nettype wire

// File: testbench/dcso_core_properties.sv
// port assertions for the converter control core
// assumes it is bound onto dcso_core, one system clock domain
`timescale 1ns/1ps
`default_nettype none
module dcso_core_props (
  // clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  // link and pins
  input wire logic link_frame_n,
  input wire logic link_sdo_oe_n,
  input wire logic load_dac_strobe_n,
  input wire logic clear_to_code_n,
  input wire logic device_reset_n,
  // converter side
  input wire logic [15:0] dac_code,
  input wire logic coding_select,
  input wire logic bias_comp_select,
  input wire logic amp_power_en,
  input wire dcso_pkg::dcso_out_state_t out_state
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (srst);
  // nothing outside asks for a change
  wire logic idle = link_frame_n & load_dac_strobe_n & clear_to_code_n
    & device_reset_n;

  a_state_one_hot: assert property ($onehot(out_state))
    else $error("output state not one-hot");
  a_reset_defaults: assert property ($fell(srst)
    |-> dac_code == 16'h8000
    && out_state == 3'b100 && !coding_select && bias_comp_select)
    else $error("wrong values after reset");
  a_pin_reset_held: assert property (!device_reset_n [*6]
    |-> out_state == 3'b100 && dac_code == 16'h8000)
    else $error("reset pin not honoured");
  a_amp_power_inv: assert property (
    amp_power_en != bias_comp_select)
    else $error("amplifier power not inverse of bias select");
  a_quiet_when_idle: assert property (idle [*8]
    |-> $stable(dac_code) && $stable(out_state))
    else $error("output moved with no cause");
  a_oe_outside_frame: assert property (
    link_frame_n |-> link_sdo_oe_n)
    else $error("serial out driven outside a frame");
  a_state_only_framed: assert property ($changed(out_state)
    && device_reset_n |-> link_frame_n)
    else $error("output state changed inside a frame");
  a_mode_only_framed: assert property ($changed({coding_select,
    bias_comp_select}) && device_reset_n |-> link_frame_n)
    else $error("mode bits changed inside a frame");
endmodule // dcso_core_props

bind dcso_core dcso_core_props u_dcso_core_props (.sys_clk(sys_clk),
  .srst(srst), .link_frame_n(link_frame_n), .link_sdo_oe_n(link_sdo_oe_n),
  .load_dac_strobe_n(load_dac_strobe_n), .clear_to_code_n(clear_to_code_n),
  .device_reset_n(device_reset_n), .dac_code(dac_code),
  .coding_select(coding_select), .bias_comp_select(bias_comp_select),
  .amp_power_en(amp_power_en), .out_state(out_state));
`default_nettype wire

// File: testbench/dcso_host_model.sv
// host serial controller model writing and reading 24-bit frames
// assumes a 12 ns link clock that stands still between frames
`timescale 1ns/1ps
`default_nettype none
module dcso_host_model (
  // serial link
  output logic link_sclk,
  output logic link_frame_n,
  output logic link_sdin,
  input wire logic link_sdo,
  input wire logic link_sdo_oe_n
);
  // idle link: clock low, frame closed
  initial begin
    link_sclk = 1'b0;
    link_frame_n = 1'b1;
    link_sdin = 1'b0;
  end
  // msb first; n below 24 is a deliberately broken frame
  task automatic xfer(input logic [23:0] w, input int n,
    output logic [23:0] rd);
    rd = '0;
    link_frame_n = 1'b0;
    #6;
    for (int i = 0; i < n; i++) begin
      link_sdin = w[23-i];
      link_sclk = 1'b1;
      #6;
      rd = {rd[22:0], link_sdo_oe_n ? ~link_sdin : link_sdo};
      link_sclk = 1'b0;
      #6;
    end
    link_frame_n = 1'b1;
    link_sdin = ~link_sdin; // released line must not keep a stale bit
  endtask
endmodule // dcso_host_model
`default_nettype wire

// File: testbench/tb.sv
// self-checking bench for the converter control core
// assumes the host model drives the link; pins are driven here
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin \
  tests_run++; \
  if ((a) !== (b)) begin \
    miscompares++; \
    $display("ERROR %0t got %h want %h", $time, (a), (b)); \
  end \
end
module tb;
  logic sys_clk, srst, link_sclk, link_frame_n, link_sdin, link_sdo;
  logic link_sdo_oe_n, load_dac_strobe_n, clear_to_code_n, device_reset_n;
  logic [15:0] dac_code, clr, pend, e_dac;
  logic coding_select, bias_comp_select, amp_power_en, e_cod, e_bias;
  dcso_pkg::dcso_out_state_t out_state;
  int miscompares = 0, tests_run = 0, cycles = 0;
  logic [20:0] q[$], prv, want;
  logic [15:0] rnd = 16'h6B4B;
  logic [23:0] rd;
  logic [2:0] e_st;
  logic [3:0] modes [5] = '{4'h2, 4'h7, 4'h8, 4'h5, 4'h8};
  wire logic [20:0] obs = {coding_select, bias_comp_select, out_state,
    dac_code};

  dcso_core u_dcso_core (.sys_clk, .srst, .link_sclk, .link_frame_n,
    .link_sdin, .link_sdo, .link_sdo_oe_n, .load_dac_strobe_n,
    .clear_to_code_n, .device_reset_n, .dac_code, .coding_select,
    .bias_comp_select, .amp_power_en, .out_state);
  dcso_host_model u_dcso_host_model (.link_sclk, .link_frame_n,
    .link_sdin, .link_sdo, .link_sdo_oe_n);

  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  // each output change is matched to the oldest queued expectation
  // sampled mid-cycle so outputs launched on the rising edge are settled
  always @(negedge sys_clk) begin
    if (!srst && obs !== prv) begin
      want = q.size() ? q.pop_front() : prv;
      `CHK(obs, want)
    end
    prv <= obs;
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      miscompares++;
      report_and_stop();
    end
  end

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic push();
    q.push_back({e_cod, e_bias, e_st, e_dac});
  endtask
  task automatic wait_n(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic wr(input logic [2:0] a, input logic [19:0] d);
    u_dcso_host_model.xfer({1'b0, a, d}, 24, rd);
    wait_n(10);
  endtask
  // m is {coding, clamp, tristate, bias}
  task automatic ctrl(input logic [3:0] m);
    e_cod = m[3];
    e_bias = m[0];
    e_st = m[2] ? 3'b100 : (m[1] ? 3'b010 : 3'b001);
    push();
    wr(3'h2, {15'h0, m, 1'b0});
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  initial begin
    srst = 1'b1;
    load_dac_strobe_n = 1'b1;
    clear_to_code_n = 1'b1;
    device_reset_n = 1'b1;
    e_cod = 1'b0;
    e_bias = 1'b1;
    e_st = 3'b100;
    e_dac = 16'h8000;
    wait_n(2);
    srst = 1'b0;
    rnd = lfsr(rnd);
    clr = rnd;
    rnd = lfsr(rnd);
    pend = clr ^ (rnd | 16'h0001);
    wr(3'h3, {clr, rnd[3:0] | 4'h1});
    wr(3'h1, {pend, 4'h0});
    // load pin while clamped: code moves, clamp stays
    e_dac = pend;
    push();
    load_dac_strobe_n = 1'b0;
    wait_n(2);
    load_dac_strobe_n = 1'b1;
    wait_n(8);
    ctrl(4'h0);
    foreach (modes[i]) ctrl(modes[i]);
    // software clear then load, coding now offset binary
    e_dac = clr;
    push();
    wr(3'h4, 20'h00002);
    e_dac = pend;
    push();
    wr(3'h4, 20'h00001);
    // strobes refused while the other pin is held low
    load_dac_strobe_n = 1'b0;
    wait_n(8);
    wr(3'h4, 20'h00002);
    load_dac_strobe_n = 1'b1;
    e_dac = clr;
    push();
    clear_to_code_n = 1'b0;
    wait_n(8);
    wr(3'h1, {~pend, 4'h0});
    wr(3'h4, 20'h00001);
    clear_to_code_n = 1'b1;
    e_dac = ~pend;
    push();
    wr(3'h4, 20'h00001);
    // read back, unmapped write and a short frame change nothing
    u_dcso_host_model.xfer({1'b1, 3'h3, 20'h0}, 24, rd);
    wait_n(6);
    u_dcso_host_model.xfer({1'b1, 3'h3, 20'h0}, 24, rd);
    `CHK(rd[23:4], {1'b1, 3'h3, clr})
    wait_n(6);
    wr(3'h7, 20'hFFFFF);
    u_dcso_host_model.xfer({1'b0, 3'h2, 20'h0001E}, 23, rd);
    wait_n(10);
    // software reset, release, then the reset pin
    e_cod = 1'b0;
    e_bias = 1'b1;
    e_st = 3'b100;
    e_dac = 16'h8000;
    push();
    wr(3'h4, 20'h00004);
    ctrl(4'h0);
    e_bias = 1'b1;
    e_st = 3'b100;
    push();
    device_reset_n = 1'b0;
    wait_n(8);
    device_reset_n = 1'b1;
    wait_n(8);
    `CHK(q.size(), 0)
    report_and_stop();
  end
endmodule // tb
`default_nettype wire
